//--- rtl/dpc_defines.svh
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
// Register word addresses on the plain port.
`define DPC_ADDR_W 8
`define DPC_A_CTRL 8'h00
`define DPC_A_CFG2 8'h01
`define DPC_A_PSEL 8'h02
`define DPC_A_STEP_LO 8'h03
`define DPC_A_STEP_HI 8'h04
`define DPC_A_POFF 8'h05
`define DPC_A_UPDATE 8'h06
`define DPC_A_STATUS 8'h07
`define DPC_A_PHASE_LO 8'h08
`define DPC_A_PHASE_HI 8'h09
// Control register field positions.
`define DPC_CTRL_RDIV_LSB 0
`define DPC_CTRL_SWAP_BIT 2
`define DPC_CTRL_XTAL_BIT 3
`define DPC_CTRL_RINT_BIT 4
`define DPC_CTRL_RISE_LSB 8
`define DPC_CTRL_FALL_LSB 12
`define DPC_CTRL_RESET 32'h0000_0000
// Second control register field positions.
`define DPC_CFG2_CPS_LSB 0
`define DPC_CFG2_MDIV_LSB 4
`define DPC_CFG2_NDIV_LSB 8
`define DPC_CFG2_RESET 32'h0000_0000
// Subclock divide ratio for update sampling.
`define DPC_SUB_DIV 4
`endif

//--- rtl/dpc_pkg.sv
package dpc_pkg;
   // One profile: step word and phase offset.
   typedef struct packed {
      logic [47:0] step;
      logic [13:0] poff;
   } dpc_prof_type;
   // Update sequencer states.
   typedef enum logic [1:0] {
      DPC_IDLE = 2'b00,
      DPC_ARM = 2'b01
   } dpc_upd_type;
endpackage

//--- rtl/dpc_fifo.sv
`timescale 1ns/1ps
// Small flip-flop FIFO with valid and ready on both sides.
module dpc_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 4
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rstn,
   // Fill side.
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // Drain side.
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, rp_r;
   logic [AW:0] cnt_r;
   wire push = i_valid && (cnt_r != (AW+1)'(DEPTH));
   wire pop = i_ready && (cnt_r != '0);
   assign o_ready = cnt_r != (AW+1)'(DEPTH);
   assign o_valid = cnt_r != '0;
   assign o_data = mem_r[rp_r];
   // Pointers and count advance on push and pop.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
         if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // Storage write.
   always_ff @(posedge i_clk) begin
      if (push) mem_r[wp_r] <= i_data;
   end
endmodule // dpc_fifo

//--- rtl/dpc_core.sv
`timescale 1ns/1ps
`include "dpc_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE_01] 48-bit accumulator steps each sample, wraps.
// [RULE_02] Add step word; step range 0..2^47; only step-high writes are clipped to it.
// [RULE_03] Add phase offset before amplitude conversion.
// [RULE_04] Cosine of phase, full range one turn.
// [RULE_05] One 14-bit amplitude word per sample.
// [RULE_06] RF divider ratio 1, 2, 4 or 8.
// [RULE_07] Software engages divider above 400 MHz input.
// [RULE_08] Divided/undivided clock routing swap option.
// [RULE_09] Reference and feedback dividers, 1 to 16.
// [RULE_10] Software enables input dividers above 200 MHz.
// [RULE_11] Pump current times 1..8 by 3-bit field.
// [RULE_12] Option enables crystal oscillator on reference.
// [RULE_13] Bit enables internal driver current resistor.
// [RULE_14] Independent rise and fall slew settings.
// [RULE_15] Eight profiles chosen by profile select inputs.
// [RULE_16] Buffered writes copy on update at subclock.
// [RULE_17] Scale field n means multiplier n plus one.
// [RULE_18] Datapath in sample domain, amplitude registered.
//////////////////////////////////////////////////////////////////////////////
module dpc_core
   import dpc_pkg::*;
#(
   parameter int NPROF = 8,
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rstn,
   // Register port.
   input wire logic [`DPC_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Profile select and transfer strobe.
   input wire logic [2:0] i_profile_select_inputs,
   input wire logic i_update,
   // Converter stream.
   output logic [13:0] o_dac_data,
   output logic o_dac_valid,
   input wire logic i_dac_ready,
   // Clock path and analog option controls.
   output logic o_sample_tick,
   output logic [1:0] o_rf_div_sel,
   output logic o_rf_route_swap,
   output logic [3:0] o_ref_div_ratio,
   output logic [3:0] o_fb_div_ratio,
   output logic [3:0] o_pump_mult,
   output logic o_xtal_osc_en,
   output logic o_drv_int_rset,
   output logic [3:0] o_drv_rise_slew,
   output logic [3:0] o_drv_fall_slew
);
   //////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops.
   logic rst_s1_r, rst_n_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end
   //////////////////////////////////////////////////////////////////////////
   // Buffered (written) and active register sets.
   logic [31:0] ctrl_buf_r, ctrl_act_r; // Control word.
   logic [31:0] cfg2_buf_r, cfg2_act_r; // Second control register.
   logic [2:0] psel_r; // Profile chosen for software writes.
   dpc_prof_type prof_buf_r [NPROF]; // Buffered profiles.
   dpc_prof_type prof_act_r [NPROF]; // Active profiles.
   logic sw_upd_r; // Software-requested transfer pending.
   // Address decode as named wires.
   wire wr_ctrl = i_wr && (i_addr == `DPC_A_CTRL);
   wire wr_cfg2 = i_wr && (i_addr == `DPC_A_CFG2);
   wire wr_psel = i_wr && (i_addr == `DPC_A_PSEL);
   wire wr_slo = i_wr && (i_addr == `DPC_A_STEP_LO);
   wire wr_shi = i_wr && (i_addr == `DPC_A_STEP_HI);
   wire wr_poff = i_wr && (i_addr == `DPC_A_POFF);
   wire wr_upd = i_wr && (i_addr == `DPC_A_UPDATE) && i_wdata[0];
   // Step-high writes above 2^47 are clipped to 2^47; step-low writes are not limited.
   wire [47:0] step_cur = prof_buf_r[psel_r].step;
   wire [47:0] step_lo_new = {step_cur[47:32], i_wdata};
   wire [47:0] step_hi_new = {i_wdata[15:0], step_cur[31:0]};
   wire [47:0] step_lim = 48'h8000_0000_0000;
   //////////////////////////////////////////////////////////////////////////
   // Subclock divider; transfers happen on its rising edge (tick).
   logic [2:0] sub_cnt_r;
   wire sub_tick = (sub_cnt_r == 3'(`DPC_SUB_DIV - 1));
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) sub_cnt_r <= '0;
      else sub_cnt_r <= sub_tick ? '0 : sub_cnt_r + 3'h1;
   end
   wire do_xfer = sub_tick && (i_update || sw_upd_r); // see [RULE_16]
   //////////////////////////////////////////////////////////////////////////
   // Buffered register writes.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_buf_r <= `DPC_CTRL_RESET;
         cfg2_buf_r <= `DPC_CFG2_RESET;
         psel_r <= '0;
         sw_upd_r <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_buf_r <= i_wdata;
         if (wr_cfg2) cfg2_buf_r <= i_wdata;
         if (wr_psel) psel_r <= i_wdata[2:0];
         // A new request wins over the completing transfer.
         if (wr_upd) sw_upd_r <= 1'b1;
         else if (do_xfer) sw_upd_r <= 1'b0;
      end
   end
   // Profile buffers, one write port per field.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         for (int k = 0; k < NPROF; k++) prof_buf_r[k] <= '0;
      end else begin
         if (wr_slo) prof_buf_r[psel_r].step <= step_lo_new;
         if (wr_shi) begin
            prof_buf_r[psel_r].step <= (step_hi_new > step_lim) ? step_lim : step_hi_new; // see [RULE_02]
         end
         if (wr_poff) prof_buf_r[psel_r].poff <= i_wdata[13:0];
      end
   end
   // Copy buffers into the active set on a qualified transfer.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_act_r <= `DPC_CTRL_RESET;
         cfg2_act_r <= `DPC_CFG2_RESET;
         for (int k = 0; k < NPROF; k++) prof_act_r[k] <= '0;
      end else if (do_xfer) begin // see [RULE_16]
         ctrl_act_r <= ctrl_buf_r;
         cfg2_act_r <= cfg2_buf_r;
         prof_act_r <= prof_buf_r;
      end
   end
   //////////////////////////////////////////////////////////////////////////
   // Sample-rate enable from the selected RF ratio.
   wire [1:0] rdiv = ctrl_act_r[`DPC_CTRL_RDIV_LSB +: 2]; // see [RULE_06]
   wire swap = ctrl_act_r[`DPC_CTRL_SWAP_BIT]; // see [RULE_08]
   logic [2:0] rf_cnt_r;
   // With swap set the core runs undivided and the driver gets the divider.
   wire [2:0] rf_mask = swap ? 3'h0 : 3'((1 << rdiv) - 1);
   wire samp_en_raw = ((rf_cnt_r & rf_mask) == rf_mask);
   wire fifo_rdy;
   logic amp_v_r; // Amplitude word waiting for the FIFO.
   // A sample waits while the last word is still refused, so no word is ever dropped.
   wire samp_en = samp_en_raw && (!amp_v_r || fifo_rdy);
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) rf_cnt_r <= '0;
      else if (!samp_en_raw || samp_en) rf_cnt_r <= rf_cnt_r + 3'h1;
   end
   //////////////////////////////////////////////////////////////////////////
   // Phase accumulator, offset and amplitude conversion.
   dpc_prof_type prof_sel;
   assign prof_sel = prof_act_r[i_profile_select_inputs]; // see [RULE_15]
   logic [47:0] acc_r;
   logic [13:0] ph_r; // Offset phase, top 14 bits.
   logic [13:0] amp_r; // Registered amplitude.
   wire [13:0] ph_nxt = acc_r[47:34] + prof_sel.poff; // see [RULE_03]
   // Quarter-wave cosine by parabolic approximation, full range one turn.
   wire [1:0] quad = ph_r[13:12];
   wire [11:0] fr = quad[0] ? (12'hfff - ph_r[11:0]) : ph_r[11:0];
   wire [23:0] sq = fr * fr;
   wire [12:0] mag = 13'h1fff - 13'(sq[23:11]);
   wire neg = quad[0] ^ quad[1];
   wire [13:0] amp_nxt = neg ? (14'h2000 - 14'(mag)) : (14'h2000 + 14'(mag) - 14'h1); // see [RULE_04]
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         acc_r <= '0;
         ph_r <= '0;
         amp_r <= 14'h2000;
         amp_v_r <= 1'b0;
      end else begin
         // The word stays offered until the FIFO has room for it.
         amp_v_r <= samp_en || (amp_v_r && !fifo_rdy);
         if (samp_en) begin // see [RULE_18]
            acc_r <= acc_r + prof_sel.step; // see [RULE_01] see [RULE_02]
            ph_r <= ph_nxt;
            amp_r <= amp_nxt; // see [RULE_05]
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////
   // Output FIFO towards the converter.
   wire fifo_v;
   wire [13:0] fifo_d;
   dpc_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_rstn(rst_n_r),
      .i_valid(amp_v_r),
      .i_data(amp_r),
      .o_ready(fifo_rdy),
      .o_valid(fifo_v),
      .o_data(fifo_d),
      .i_ready(i_dac_ready)
   );
   // Registered converter output.
   wire fifo_pop = fifo_v && i_dac_ready;
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_dac_data <= 14'h2000;
         o_dac_valid <= 1'b0;
      end else begin
         o_dac_valid <= fifo_pop; // see [RULE_05]
         if (fifo_pop) o_dac_data <= fifo_d;
      end
   end
   //////////////////////////////////////////////////////////////////////////
   // Control outputs from the active set.
   wire [3:0] mult_nxt = {1'b0, cfg2_act_r[`DPC_CFG2_CPS_LSB +: 3]} + 4'h1; // see [RULE_17]
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_sample_tick <= 1'b0;
         o_rf_div_sel <= '0;
         o_rf_route_swap <= 1'b0;
         o_ref_div_ratio <= '0;
         o_fb_div_ratio <= '0;
         o_pump_mult <= 4'h1;
         o_xtal_osc_en <= 1'b0;
         o_drv_int_rset <= 1'b0;
         o_drv_rise_slew <= '0;
         o_drv_fall_slew <= '0;
      end else begin
         o_sample_tick <= samp_en;
         o_rf_div_sel <= rdiv; // see [RULE_06]
         o_rf_route_swap <= swap; // see [RULE_08]
         o_ref_div_ratio <= cfg2_act_r[`DPC_CFG2_MDIV_LSB +: 4]; // see [RULE_09]
         o_fb_div_ratio <= cfg2_act_r[`DPC_CFG2_NDIV_LSB +: 4]; // see [RULE_09]
         o_pump_mult <= mult_nxt; // see [RULE_11]
         o_xtal_osc_en <= ctrl_act_r[`DPC_CTRL_XTAL_BIT]; // see [RULE_12]
         o_drv_int_rset <= ctrl_act_r[`DPC_CTRL_RINT_BIT]; // see [RULE_13]
         o_drv_rise_slew <= ctrl_act_r[`DPC_CTRL_RISE_LSB +: 4]; // see [RULE_14]
         o_drv_fall_slew <= ctrl_act_r[`DPC_CTRL_FALL_LSB +: 4]; // see [RULE_14]
      end
   end
   //////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero.
   logic [31:0] rmux;
   always_comb begin
      case (i_addr)
         `DPC_A_CTRL: rmux = ctrl_buf_r;
         `DPC_A_CFG2: rmux = cfg2_buf_r;
         `DPC_A_PSEL: rmux = {29'h0, psel_r};
         `DPC_A_STEP_LO: rmux = step_cur[31:0];
         `DPC_A_STEP_HI: rmux = {16'h0, step_cur[47:32]};
         `DPC_A_POFF: rmux = {18'h0, prof_buf_r[psel_r].poff};
         `DPC_A_UPDATE: rmux = {31'h0, sw_upd_r};
         `DPC_A_STATUS: rmux = {29'h0, i_profile_select_inputs};
         `DPC_A_PHASE_LO: rmux = acc_r[31:0];
         `DPC_A_PHASE_HI: rmux = {16'h0, acc_r[47:32]};
         default: rmux = 32'h0;
      endcase
   end
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) o_rdata <= '0;
      else o_rdata <= i_rd ? rmux : 32'h0;
   end
endmodule // dpc_core

//--- verification/dpc_core_props.sv
`timescale 1ns/1ps
`include "dpc_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Watches the register port and three active option outputs of the core: RF divider, pump and rise slew.
module dpc_core_props (
   // Clock, reset and register port.
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [`DPC_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // Pins and outputs under watch.
   input wire logic [2:0] i_profile_select_inputs,
   input wire logic i_update,
   input wire logic o_dac_valid,
   input wire logic i_dac_ready,
   input wire logic o_sample_tick,
   input wire logic [1:0] o_rf_div_sel,
   input wire logic [3:0] o_pump_mult,
   input wire logic [3:0] o_drv_rise_slew
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // Cycles since the transfer strobe was last high, saturating.
   logic [3:0] since_upd_r;
   // Restarts on every strobe so that late transfers are caught.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) since_upd_r <= 4'hf;
      else if (i_update || (i_wr && i_addr == `DPC_A_UPDATE && i_wdata[0]))
         since_upd_r <= 4'h0;
      else if (since_upd_r != 4'hf) since_upd_r <= since_upd_r + 4'h1;
   end
   // A write followed by a read of the same place shows the written bits.
   property p_rb(logic [7:0] a, logic [31:0] m);
      i_wr && i_addr == a ##2 i_rd && i_addr == a |=> (o_rdata & m) == ($past(i_wdata, 3) & m);
   endproperty
   chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
      else $error("read data not zero while idle");
   chk_unmapped_zero: assert property (i_rd && i_addr > `DPC_A_PHASE_HI |=> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_status_pins: assert property (i_rd && i_addr == `DPC_A_STATUS
      |=> o_rdata[2:0] == $past(i_profile_select_inputs))
      else $error("status does not show profile pins");
   chk_ctrl_readback: assert property (p_rb(`DPC_A_CTRL, 32'h0000_ff1f))
      else $error("control readback wrong");
   chk_cfg2_readback: assert property (p_rb(`DPC_A_CFG2, 32'h0000_0ff7))
      else $error("second control readback wrong");
   chk_psel_readback: assert property (p_rb(`DPC_A_PSEL, 32'h0000_0007))
      else $error("profile pointer readback wrong");
   chk_pump_span: assert property (o_pump_mult >= 4'h1 && o_pump_mult <= 4'h8)
      else $error("pump multiplier out of span");
   chk_cfg_on_update: assert property ($changed({o_rf_div_sel, o_pump_mult,
      o_drv_rise_slew}) |-> since_upd_r <= 4'h6)
      else $error("active setting changed without transfer");
   cover property (o_dac_valid && i_dac_ready);
   cover property (o_sample_tick && !i_dac_ready);
   cover property (i_update ##[1:8] $changed(o_pump_mult));
endmodule // dpc_core_props

//--- verification/dpc_dac_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Converter stand-in: takes amplitude words and stalls at random when told.
module dpc_dac_model (
   // Clock and stall control.
   input wire logic i_clk,
   input wire logic i_stall_en,
   // Word stream from the core.
   input wire logic i_valid,
   output logic o_ready,
   output int o_taken
);
   int seed = 32'h063cba96; // Own fixed seed for the stall pattern.
   // Ready starts high so the core never waits before stalling is asked.
   initial begin
      o_ready = 1'b1;
      o_taken = 0;
   end
   // Every delivered word is counted; ready drops a third of the time when stalling.
   always @(posedge i_clk) begin
      if (i_valid) o_taken <= o_taken + 1;
      o_ready <= !i_stall_en || ($random(seed) % 3 != 0);
   end
endmodule // dpc_dac_model

//--- verification/dpc_core_tb.sv
`timescale 1ns/1ps
`include "dpc_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Self-checking bench: options, register port, sample rate and cosine words.
module dpc_core_tb;
   logic i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_update = 1'b0, stall_en = 1'b0;
   logic [7:0] i_addr = 8'h0;
   logic [31:0] i_wdata = 32'h0, o_rdata, rd_val, ctrl, cfg;
   logic [2:0] i_profile_select_inputs = 3'h0;
   logic [13:0] o_dac_data, w;
   logic o_dac_valid, i_dac_ready, o_sample_tick, o_rf_route_swap, o_xtal_osc_en, o_drv_int_rset;
   logic [1:0] o_rf_div_sel;
   logic [3:0] o_ref_div_ratio, o_fb_div_ratio, o_pump_mult, o_drv_rise_slew, o_drv_fall_slew;
   int bad_count = 0, check_count = 0, cycles = 0, seed = 32'h063cba96, taken, n, k, q;
   // Ideal cosine at quarter turns, offset binary, and the profile table.
   logic [13:0] quad [4] = '{14'h3fff, 14'h2000, 14'h0000, 14'h2000};
   logic [15:0] hi_t [5] = '{16'h0, 16'h0, 16'h0, 16'h8000, 16'h4000};
   logic [13:0] po_t [5] = '{14'h1000, 14'h2000, 14'h3000, 14'h0, 14'h0};
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   dpc_core dpc_core_inst (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_profile_select_inputs, .i_update, .o_dac_data, .o_dac_valid, .i_dac_ready,
      .o_sample_tick, .o_rf_div_sel, .o_rf_route_swap, .o_ref_div_ratio, .o_fb_div_ratio,
      .o_pump_mult, .o_xtal_osc_en, .o_drv_int_rset, .o_drv_rise_slew, .o_drv_fall_slew);
   dpc_dac_model dpc_dac_model_inst (.i_clk, .i_stall_en(stall_en), .i_valid(o_dac_valid),
      .o_ready(i_dac_ready), .o_taken(taken));
   // Compares and counts; a mismatch is reported at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One-cycle write strobe.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   // One-cycle read strobe; the data are taken in the following cycle only.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      d = o_rdata;
   endtask
   // Holds the transfer strobe across a whole subclock period.
   task automatic upd();
      @(posedge i_clk) i_update <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_update <= 1'b0;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   // Waits for the next delivered word, bounded.
   task automatic get_word(output logic [13:0] d);
      n = 0;
      do @(negedge i_clk); while (o_dac_valid !== 1'b1 && ++n < 200);
      if (n >= 200) bad_count++;
      d = o_dac_data;
   endtask
   // Passes the ideal value only when the word lies near it.
   function automatic logic [13:0] near(input logic [13:0] g, input logic [13:0] e);
      return ((g > e ? g - e : e - g) <= 14'h40) ? e : g;
   endfunction
   // A hang counts as a mismatch and ends the run.
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (3) @(negedge i_clk);
      check(32'(o_pump_mult), 32'h1);
      check(32'(o_dac_data), 32'h2000);
      k = 1;
      // Every pump code and divider code, with random other options.
      for (int i = 0; i < 8; i++) begin
         ctrl = ($random(seed) & 32'h0000_ff1c) | (i & 3);
         cfg = ($random(seed) & 32'h0000_0ff0) | i;
         wr(`DPC_A_CTRL, ctrl);
         rd(`DPC_A_CTRL, rd_val);
         check(rd_val & 32'hff1f, ctrl);
         wr(`DPC_A_CFG2, cfg);
         rd(`DPC_A_CFG2, rd_val);
         check(rd_val & 32'h0ff7, cfg);
         check(32'(o_pump_mult), 32'(k));
         upd();
         k = i + 1;
         check({o_drv_fall_slew, o_drv_rise_slew, 3'h0, o_drv_int_rset, o_xtal_osc_en,
            o_rf_route_swap, o_rf_div_sel}, ctrl);
         check({o_fb_div_ratio, o_ref_div_ratio, o_pump_mult - 4'h1}, cfg);
      end
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, rd_val);
      check(rd_val, 32'h0);
      @(posedge i_clk) i_profile_select_inputs <= 3'h5;
      rd(`DPC_A_STATUS, rd_val);
      check(rd_val & 32'h7, 32'h5);
      // Sample rate and delivered word rate follow the divider ratio.
      for (int s = 0; s < 4; s++) begin
         wr(`DPC_A_CTRL, 32'(s));
         upd();
         n = 0;
         q = taken;
         repeat (128) @(negedge i_clk) n += int'(o_sample_tick);
         k = 128 >> s;
         check(32'((n - k) * (n - k) <= 1 ? k : n), 32'(k));
         n = taken - q;
         check(32'((n - k) * (n - k) <= 4 ? k : n), 32'(k));
      end
      @(posedge i_clk) stall_en <= 1'b1;
      // Profiles: fixed offsets, then half-turn and quarter-turn steps.
      for (int j = 0; j < 5; j++) begin
         @(posedge i_clk) i_profile_select_inputs <= 3'(j);
         wr(`DPC_A_PSEL, 32'(j));
         rd(`DPC_A_PSEL, rd_val);
         check(rd_val & 32'h7, 32'(j));
         wr(`DPC_A_STEP_LO, 32'h0);
         wr(`DPC_A_STEP_HI, 32'(hi_t[j]));
         wr(`DPC_A_POFF, 32'(po_t[j]));
         upd();
         repeat (10) get_word(w);
         q = po_t[j] >> 12;
         for (int m = 0; m < 8 && hi_t[j] != 16'h0 && near(w, 14'h3fff) !== 14'h3fff; m++) get_word(w);
         for (int m = 0; m < 16; m++) begin
            check(32'(near(w, quad[q % 4])), 32'(quad[q % 4]));
            q += hi_t[j] >> 14;
            get_word(w);
         end
      end
      // Step-high writes above the valid range are clipped to half a turn.
      wr(`DPC_A_STEP_HI, 32'h0000_ffff);
      rd(`DPC_A_STEP_HI, rd_val);
      check(rd_val, 32'h0000_8000);
      rd(`DPC_A_STEP_LO, rd_val);
      check(rd_val, 32'h0);
      // A write alone changes nothing; a software request applies it at the next tick.
      wr(`DPC_A_CTRL, 32'h0000_0001);
      repeat (8) @(negedge i_clk);
      check(32'(o_rf_div_sel), 32'h3);
      wr(`DPC_A_UPDATE, 32'h0000_0001);
      repeat (8) @(negedge i_clk);
      check(32'(o_rf_div_sel), 32'h1);
      rd(`DPC_A_UPDATE, rd_val);
      check(rd_val, 32'h0);
      end_sim();
   end
endmodule // dpc_core_tb
bind dpc_core dpc_core_props dpc_core_props_inst (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr,
   .i_rd, .o_rdata, .i_profile_select_inputs, .i_update, .o_dac_valid, .i_dac_ready,
   .o_sample_tick, .o_rf_div_sel, .o_pump_mult, .o_drv_rise_slew);
